// [hdl/bit_rate_gen.sv]
`timescale 1ns/1ps
`include "usb_policy_defs.svh"

module bit_rate_gen #(
  parameter int CLK_KHZ = `CLK_KHZ,
  parameter int FAST_KHZ = `FS_RATE_KHZ,
  parameter int SLOW_KHZ = `LS_RATE_KHZ
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic slow, // 1: slow rate
  output logic bit_tick // one-cycle pulse per bit time
);

  // Modulo accumulator keeps the average rate exact with no fractional drift
  logic [31:0] acc;
  logic [31:0] next_acc;
  logic next_tick;
  logic [31:0] step;
  logic [31:0] sum;

  always_comb begin
    step = slow ? 32'(SLOW_KHZ) : 32'(FAST_KHZ);
    sum = acc + step;
    if (sum >= 32'(CLK_KHZ)) begin
      next_acc = sum - 32'(CLK_KHZ);
      next_tick = 1'b1;
    end else begin
      next_acc = sum;
      next_tick = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc <= 32'h0;
      bit_tick <= 1'b0;
    end else begin
      acc <= next_acc;
      bit_tick <= next_tick;
    end
  end

endmodule : bit_rate_gen

// [hdl/usb_otg_role_speed_policy.sv]
// Functional notes
// - Plug identity low (micro-A) selects host role; high (micro-B) selects peripheral.
// - Host negotiation swaps roles between linked peers without re-plugging the cable.
// - Full speed in both roles; low speed offered only in host role.
// - Full speed signals at 12 Mb/s, low speed at 1.5 Mb/s.
// - As peripheral, pull up D+ for full speed, D- for low speed.
// - Host alone starts transfers and allocates bandwidth; peripheral never starts one.
// - Host keeps 10% of each frame for control; rest goes to periodic traffic.
// - Bulk only gets bandwidth left after control and periodic needs.
// - Interrupt pipe is polled in slots at the configured frame interval.
// - Isochronous data is CRC checked but never handshaken.
// - Up to 16 endpoints, each bound to one transaction type.
// - Endpoint 0 is always the default control endpoint.
// - As B-side peer, session request uses data-line and bus-supply pulsing.
// - Host tells apart up to 127 devices by a 7-bit address.
`timescale 1ns/1ps
`include "usb_policy_defs.svh"

module usb_otg_role_speed_policy
  import usb_policy_pkg::*;
#(
  parameter int EP_COUNT = `EP_COUNT,
  parameter int FRAME_CYC = `FRAME_CYC,
  parameter int SRP_DLINE_CYC = `SRP_DLINE_CYC,
  parameter int SRP_GAP_CYC = `SRP_GAP_CYC,
  parameter int SRP_VBUS_CYC = `SRP_VBUS_CYC,
  parameter bit DEV_LS_ALLOWED = 1'b0
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic plug_identity_pin, // plug identity pin, asynchronous
  input wire logic hnp_enable, // peer supports role negotiation
  input wire logic hnp_request, // pulse: swap host and peripheral
  input wire logic low_speed_req, // request low-speed operation
  input wire logic attach_en, // peripheral may connect pull-up
  input wire logic session_req, // pulse: start a session request
  input wire logic req_valid, // host transfer request
  input wire logic [1:0] req_type, // transfer type, xfer_t coding
  input wire logic [3:0] req_ep, // target endpoint
  input wire logic [`DEV_ADDR_W-1:0] req_addr, // target device address
  input wire logic [13:0] req_bits, // bus bit-times the transfer costs
  input wire logic [13:0] periodic_demand, // periodic bits still owed this frame
  input wire logic [7:0] int_poll_interval, // interrupt poll period in frames
  input wire logic [EP_COUNT-1:0] ep_enable, // endpoint enables
  input wire logic [2*EP_COUNT-1:0] ep_type_cfg, // per-endpoint transfer type
  input wire logic rx_tok_valid, // peripheral: token arrived
  input wire logic [3:0] rx_tok_ep, // peripheral: token endpoint
  input wire logic [1:0] rx_tok_type, // peripheral: token transfer type
  output logic req_ready, // request can be granted now
  output logic host_role, // 1: acting as host
  output logic low_speed, // 1: low-speed signalling active
  output logic bit_tick, // bit-time strobe at the bus rate
  output logic dp_pullup_en, // D+ pull-up enable
  output logic dm_pullup_en, // D- pull-up enable
  output logic sof, // pulse at each frame start
  output logic int_poll_due, // interrupt poll slot open
  output logic tok_valid, // pulse: host starts a transfer
  output xfer_t tok_type, // started transfer type
  output logic [3:0] tok_ep, // started transfer endpoint
  output logic [`DEV_ADDR_W-1:0] tok_addr, // started transfer address
  output logic tok_handshake, // transfer expects a handshake
  output logic tok_crc_check, // data is CRC checked
  output logic rx_tok_accept, // pulse: received token accepted
  output logic srp_dline_pulse, // session request data-line pulse
  output logic srp_vbus_pulse, // session request bus-supply pulse
  output logic srp_busy // session request in progress
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [13:0] frame_bits(input logic ls);
    frame_bits = ls ? 14'(`LS_FRAME_BITS) : 14'(`FS_FRAME_BITS);
  endfunction : frame_bits

  function automatic logic [13:0] ctrl_reserve(input logic ls);
    ctrl_reserve = 14'((32'(frame_bits(ls)) * `CTRL_RESERVE_PCT + 99) / 100);
  endfunction : ctrl_reserve

  // Endpoint 0 is forced to control whatever the configuration says
  function automatic logic ep_match(input logic [3:0] ep, input logic [1:0] typ,
                                    input logic [EP_COUNT-1:0] en,
                                    input logic [2*EP_COUNT-1:0] cfg);
    logic [1:0] bound;
    bound = cfg[2*ep +: 2];
    if (32'(ep) >= EP_COUNT) begin
      ep_match = 1'b0;
    end else if (ep == `EP_DEFAULT_CTRL) begin
      ep_match = en[ep] && (typ == XFER_CTRL);
    end else begin
      ep_match = en[ep] && (typ == bound);
    end
  endfunction : ep_match

  ////////////////////////////////////////////////////////////////////////////////
  // Plug identity synchroniser, role and negotiation

  logic id_meta;
  logic id_sync;
  logic id_prev;
  logic role_swapped;
  logic next_role_swapped;
  logic next_host_role;
  logic b_side;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      id_meta <= 1'b1;
      id_sync <= 1'b1;
    end else begin
      id_meta <= plug_identity_pin;
      id_sync <= id_meta;
    end
  end

  assign b_side = (id_sync != `PLUG_A_LEVEL);

  always_comb begin
    next_role_swapped = role_swapped;
    if (id_sync != id_prev) begin
      // A plug change ends any negotiated swap
      next_role_swapped = 1'b0;
    end else if (hnp_request && hnp_enable && !srp_busy) begin
      next_role_swapped = !role_swapped;
    end
    next_host_role = !b_side ^ next_role_swapped;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      id_prev <= 1'b1;
      role_swapped <= 1'b0;
      host_role <= 1'b0;
    end else begin
      id_prev <= id_sync;
      role_swapped <= next_role_swapped;
      host_role <= next_host_role;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Speed, pull-ups and bit rate

  logic next_low_speed;
  logic dev_ls;
  logic next_dp;
  logic next_dm;

  always_comb begin
    next_low_speed = host_role && low_speed_req;
    // Peripheral low speed is off unless the build allows it
    dev_ls = DEV_LS_ALLOWED && low_speed_req;
    next_dp = !host_role && ((attach_en && !dev_ls) || srp_dline_pulse);
    next_dm = !host_role && attach_en && dev_ls;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_speed <= 1'b0;
      dp_pullup_en <= 1'b0;
      dm_pullup_en <= 1'b0;
    end else begin
      low_speed <= next_low_speed;
      dp_pullup_en <= next_dp;
      dm_pullup_en <= next_dm;
    end
  end

  bit_rate_gen u_rate (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .slow(low_speed),
    .bit_tick(bit_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Frame timing, budget and interrupt polling

  logic [31:0] frame_cnt;
  logic [31:0] next_frame_cnt;
  logic next_sof;
  logic [13:0] budget_left;
  logic [13:0] periodic_used;
  logic [13:0] ctrl_used;
  logic [13:0] next_budget_left;
  logic [13:0] next_periodic_used;
  logic [13:0] next_ctrl_used;
  logic [7:0] poll_cnt;
  logic [7:0] next_poll_cnt;
  logic next_int_poll_due;
  logic grant;
  xfer_t req_kind;

  assign req_kind = xfer_t'(req_type);

  always_comb begin
    next_sof = (frame_cnt == 32'(FRAME_CYC - 1));
    next_frame_cnt = next_sof ? 32'h0 : frame_cnt + 32'h1;
    next_budget_left = budget_left;
    next_periodic_used = periodic_used;
    next_ctrl_used = ctrl_used;
    next_poll_cnt = poll_cnt;
    next_int_poll_due = int_poll_due;
    if (grant) begin
      next_budget_left = budget_left - req_bits;
      if (req_kind == XFER_CTRL) begin
        next_ctrl_used = ctrl_used + req_bits;
      end else if (req_kind != XFER_BULK) begin
        next_periodic_used = periodic_used + req_bits;
      end
      if (req_kind == XFER_INT) begin
        next_int_poll_due = 1'b0;
      end
    end
    if (next_sof) begin
      next_budget_left = frame_bits(low_speed);
      next_periodic_used = 14'h0;
      next_ctrl_used = 14'h0;
      // Opening a poll slot wins over a grant in the same cycle
      if (poll_cnt == 8'h0) begin
        next_poll_cnt = (int_poll_interval == 8'h0) ? 8'h0 : int_poll_interval - 8'h1;
        next_int_poll_due = 1'b1;
      end else begin
        next_poll_cnt = poll_cnt - 8'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frame_cnt <= 32'h0;
      sof <= 1'b0;
      budget_left <= 14'(`FS_FRAME_BITS);
      periodic_used <= 14'h0;
      ctrl_used <= 14'h0;
      poll_cnt <= 8'h0;
      int_poll_due <= 1'b0;
    end else begin
      frame_cnt <= next_frame_cnt;
      sof <= next_sof;
      budget_left <= next_budget_left;
      periodic_used <= next_periodic_used;
      ctrl_used <= next_ctrl_used;
      poll_cnt <= next_poll_cnt;
      int_poll_due <= next_int_poll_due;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bandwidth scheduler

  logic fits;
  logic [14:0] periodic_after;
  logic [13:0] periodic_cap;
  logic [13:0] reserve_unused;
  logic [15:0] bulk_need;
  logic kind_ok;

  always_comb begin
    fits = req_bits <= budget_left;
    periodic_cap = frame_bits(low_speed) - ctrl_reserve(low_speed);
    periodic_after = {1'b0, periodic_used} + {1'b0, req_bits};
    reserve_unused = (ctrl_reserve(low_speed) > ctrl_used) ?
                     ctrl_reserve(low_speed) - ctrl_used : 14'h0;
    // Bulk must leave the control reserve and the periodic demand untouched
    bulk_need = {2'b0, req_bits} + {2'b0, reserve_unused} + {2'b0, periodic_demand};
    case (req_kind)
      XFER_CTRL: kind_ok = fits;
      XFER_ISO: kind_ok = fits && (periodic_after <= {1'b0, periodic_cap});
      XFER_INT: begin
        kind_ok = fits && int_poll_due && (periodic_after <= {1'b0, periodic_cap});
      end
      XFER_BULK: kind_ok = bulk_need <= {2'b0, budget_left};
      default: kind_ok = 1'b0;
    endcase
    // Only the host starts transfers
    req_ready = host_role && kind_ok && ep_match(req_ep, req_type, ep_enable, ep_type_cfg);
    grant = req_valid && req_ready;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Issued transfer and received token check

  logic next_rx_accept;

  always_comb begin
    next_rx_accept = rx_tok_valid && !host_role &&
                     ep_match(rx_tok_ep, rx_tok_type, ep_enable, ep_type_cfg);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tok_valid <= 1'b0;
      tok_type <= XFER_CTRL;
      tok_ep <= 4'h0;
      tok_addr <= '0;
      tok_handshake <= 1'b0;
      tok_crc_check <= 1'b0;
      rx_tok_accept <= 1'b0;
    end else begin
      tok_valid <= grant;
      rx_tok_accept <= next_rx_accept;
      if (grant) begin
        tok_type <= req_kind;
        tok_ep <= req_ep;
        tok_addr <= req_addr;
        tok_handshake <= (req_kind != XFER_ISO);
        tok_crc_check <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Session request: data-line pulse, short gap, then bus-supply pulse

  srp_state_t srp_state;
  srp_state_t next_srp_state;
  logic [31:0] srp_cnt;
  logic [31:0] next_srp_cnt;

  always_comb begin
    next_srp_state = srp_state;
    next_srp_cnt = (srp_cnt == 32'h0) ? 32'h0 : srp_cnt - 32'h1;
    case (srp_state)
      SRP_IDLE: begin
        // Only a B-side peripheral may ask the host for a session
        if (session_req && b_side && !host_role) begin
          next_srp_state = SRP_DLINE;
          next_srp_cnt = 32'(SRP_DLINE_CYC - 1);
        end
      end
      SRP_DLINE: begin
        if (srp_cnt == 32'h0) begin
          next_srp_state = SRP_GAP;
          next_srp_cnt = 32'(SRP_GAP_CYC - 1);
        end
      end
      SRP_GAP: begin
        if (srp_cnt == 32'h0) begin
          next_srp_state = SRP_VBUS;
          next_srp_cnt = 32'(SRP_VBUS_CYC - 1);
        end
      end
      SRP_VBUS: begin
        if (srp_cnt == 32'h0) begin
          next_srp_state = SRP_IDLE;
        end
      end
      default: next_srp_state = SRP_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      srp_state <= SRP_IDLE;
      srp_cnt <= 32'h0;
      srp_dline_pulse <= 1'b0;
      srp_vbus_pulse <= 1'b0;
      srp_busy <= 1'b0;
    end else begin
      srp_state <= next_srp_state;
      srp_cnt <= next_srp_cnt;
      srp_dline_pulse <= (next_srp_state == SRP_DLINE);
      srp_vbus_pulse <= (next_srp_state == SRP_VBUS);
      srp_busy <= (next_srp_state != SRP_IDLE);
    end
  end

endmodule : usb_otg_role_speed_policy

// [hdl/usb_policy_defs.svh]
`ifndef USB_POLICY_DEFS_SVH
`define USB_POLICY_DEFS_SVH

// System clock and signalling rates, in kHz
`define CLK_KHZ 250000
`define FS_RATE_KHZ 12000
`define LS_RATE_KHZ 1500

// Frame length and the bit budget it holds at each speed
`define FRAME_TIME_US 1000
`define FRAME_CYC ((`FRAME_TIME_US * `CLK_KHZ) / 1000)
`define FS_FRAME_BITS ((`FRAME_TIME_US * `FS_RATE_KHZ) / 1000)
`define LS_FRAME_BITS ((`FRAME_TIME_US * `LS_RATE_KHZ) / 1000)
`define CTRL_RESERVE_PCT 10

// Session request pulse timing
`define SRP_DLINE_MS 7
`define SRP_GAP_MS 2
`define SRP_VBUS_MS 20
`define SRP_DLINE_CYC (`SRP_DLINE_MS * `CLK_KHZ)
`define SRP_GAP_CYC (`SRP_GAP_MS * `CLK_KHZ)
`define SRP_VBUS_CYC (`SRP_VBUS_MS * `CLK_KHZ)

// Endpoints, addressing, plug coding
`define EP_COUNT 16
`define EP_DEFAULT_CTRL 4'h0
`define DEV_ADDR_W 7
`define PLUG_A_LEVEL 1'b0

`endif

// [hdl/usb_policy_pkg.sv]
package usb_policy_pkg;

  typedef enum logic [1:0] {
    XFER_CTRL,
    XFER_ISO,
    XFER_INT,
    XFER_BULK
  } xfer_t;

  typedef enum logic [1:0] {
    SRP_IDLE,
    SRP_DLINE,
    SRP_GAP,
    SRP_VBUS
  } srp_state_t;

endpackage : usb_policy_pkg

// [test/usb_otg_role_speed_policy_tb_top.sv]
`timescale 1ns/1ps

module usb_otg_role_speed_policy_tb_top;
  typedef struct packed {
    logic [1:0] typ;
    logic [3:0] ep;
    logic [13:0] bits;
    logic rdy;
    logic hs;
  } row_t;
  logic clk_sys, rst_n, plug_identity_pin, hnp_enable, hnp_request, low_speed_req;
  logic attach_en, session_req, req_valid, req_ready, host_role, low_speed, bit_tick;
  logic dp_pullup_en, dm_pullup_en, sof, int_poll_due, tok_valid, tok_handshake;
  logic tok_crc_check, rx_tok_accept, srp_dline_pulse, srp_vbus_pulse, srp_busy;
  logic rx_tok_valid, send;
  logic [1:0] req_type, rx_tok_type, send_type;
  logic [3:0] req_ep, rx_tok_ep, tok_ep, send_ep;
  logic [6:0] req_addr, tok_addr;
  logic [13:0] req_bits, periodic_demand;
  logic [7:0] int_poll_interval;
  logic [15:0] ep_enable;
  logic [31:0] ep_type_cfg;
  usb_policy_pkg::xfer_t tok_type;
  int ack_count, acc_n = 0, fail_count, n_checks, i, n;
  // Budget 12000, control reserve 1200, periodic cap 10800, periodic owed 9700
  row_t rows [11] = '{'{2'h0, 4'h0, 14'd100, 1'b1, 1'b1}, '{2'h1, 4'h0, 14'd100, 1'b0, 1'b0},
    '{2'h1, 4'h1, 14'd100, 1'b1, 1'b0}, '{2'h0, 4'h1, 14'd100, 1'b0, 1'b0},
    '{2'h2, 4'h2, 14'd100, 1'b1, 1'b1}, '{2'h2, 4'h2, 14'd100, 1'b0, 1'b0},
    '{2'h1, 4'h1, 14'd11000, 1'b0, 1'b0}, '{2'h3, 4'h3, 14'd11000, 1'b0, 1'b0},
    '{2'h3, 4'h3, 14'd500, 1'b1, 1'b1}, '{2'h2, 4'h6, 14'd100, 1'b0, 1'b0},
    '{2'h3, 4'h3, 14'd500, 1'b0, 1'b0}};

  usb_otg_role_speed_policy #(.FRAME_CYC(200), .SRP_DLINE_CYC(20), .SRP_GAP_CYC(5),
    .SRP_VBUS_CYC(30)) usb_otg_role_speed_policy_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .plug_identity_pin(plug_identity_pin),
    .hnp_enable(hnp_enable), .hnp_request(hnp_request), .low_speed_req(low_speed_req),
    .attach_en(attach_en), .session_req(session_req), .req_valid(req_valid),
    .req_type(req_type), .req_ep(req_ep), .req_addr(req_addr), .req_bits(req_bits),
    .periodic_demand(periodic_demand), .int_poll_interval(int_poll_interval),
    .ep_enable(ep_enable), .ep_type_cfg(ep_type_cfg), .rx_tok_valid(rx_tok_valid),
    .rx_tok_ep(rx_tok_ep), .rx_tok_type(rx_tok_type), .req_ready(req_ready),
    .host_role(host_role), .low_speed(low_speed), .bit_tick(bit_tick),
    .dp_pullup_en(dp_pullup_en), .dm_pullup_en(dm_pullup_en), .sof(sof),
    .int_poll_due(int_poll_due), .tok_valid(tok_valid), .tok_type(tok_type),
    .tok_ep(tok_ep), .tok_addr(tok_addr), .tok_handshake(tok_handshake),
    .tok_crc_check(tok_crc_check), .rx_tok_accept(rx_tok_accept),
    .srp_dline_pulse(srp_dline_pulse), .srp_vbus_pulse(srp_vbus_pulse), .srp_busy(srp_busy));

  usb_peer_model usb_peer_model_inst (.clk_sys(clk_sys), .rst_n(rst_n), .send(send),
    .send_ep(send_ep), .send_type(send_type), .tok_valid(tok_valid),
    .tok_handshake(tok_handshake), .rx_tok_valid(rx_tok_valid), .rx_tok_ep(rx_tok_ep),
    .rx_tok_type(rx_tok_type), .ack_count(ack_count));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) if (rx_tok_accept === 1'b1) acc_n++;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  task automatic stuck;
    fail_count++;
    summarize();
  endtask : stuck

  task automatic run_row(input row_t r);
    req_type <= r.typ;
    req_ep <= r.ep;
    req_bits <= r.bits;
    req_valid <= 1'b1;
    @(negedge clk_sys);
    check(32'(req_ready), 32'(r.rdy));
    @(posedge clk_sys);
    req_valid <= 1'b0;
    @(negedge clk_sys);
    check(32'(tok_valid), 32'(r.rdy));
    if (r.rdy) check(32'({tok_type, tok_handshake}), 32'({r.typ, r.hs}));
    if (r.rdy) check(32'(tok_addr), 32'h7f);
    @(posedge clk_sys);
  endtask : run_row

  task automatic tok_send(input logic [3:0] ep, input logic [1:0] typ);
    send <= 1'b1;
    send_ep <= ep;
    send_type <= typ;
    @(posedge clk_sys);
    send <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : tok_send

  task automatic count_ticks(input int exp);
    n = 0;
    repeat (1000) begin
      @(negedge clk_sys);
      if (bit_tick === 1'b1) n++;
    end
    check(32'(n >= exp - 1 && n <= exp + 1), 32'h1);
    @(posedge clk_sys);
  endtask : count_ticks

  // Waits for the chosen pulse, then returns its length in cycles
  task automatic pulse_len(input logic vbus, output int len);
    for (i = 0; i < 60 && (vbus ? srp_vbus_pulse : srp_dline_pulse) !== 1'b1; i++)
      @(negedge clk_sys);
    if (i == 60) stuck();
    len = 0;
    while ((vbus ? srp_vbus_pulse : srp_dline_pulse) === 1'b1 && len < 100) begin
      len++;
      @(negedge clk_sys);
    end
  endtask : pulse_len

  initial begin
    repeat (100000) @(posedge clk_sys);
    stuck();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, hnp_enable, hnp_request, low_speed_req, attach_en, session_req} = '0;
    {req_valid, req_type, req_ep, req_bits, int_poll_interval} = '0;
    {send, send_ep, send_type, fail_count, n_checks} = '0;
    periodic_demand = 14'd9700;
    plug_identity_pin = 1'b1;
    req_addr = 7'h7f;
    ep_enable = 16'hffbf;
    ep_type_cfg = {4{8'he4}};
    repeat (2) @(posedge clk_sys);
    check(32'({host_role, tok_valid, dp_pullup_en}), 32'h0);
    rst_n <= 1'b1;
    $display("test reset done");
    attach_en <= 1'b1;
    low_speed_req <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check(32'(host_role), 32'h0);
    check(32'({dp_pullup_en, dm_pullup_en, low_speed}), 32'h4);
    run_row('{2'h0, 4'h0, 14'd100, 1'b0, 1'b0});
    tok_send(4'h1, 2'h1);
    tok_send(4'h1, 2'h0);
    check(32'(acc_n), 32'h1);
    count_ticks(48);
    $display("test peripheral done");
    hnp_enable <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      hnp_request <= 1'b1;
      @(posedge clk_sys);
      hnp_request <= 1'b0;
      repeat (3) @(posedge clk_sys);
      check(32'(host_role), 32'(k == 0));
    end
    $display("test swap done");
    attach_en <= 1'b0;
    session_req <= 1'b1;
    @(posedge clk_sys);
    session_req <= 1'b0;
    pulse_len(1'b0, n);
    check(32'(n), 32'd20);
    pulse_len(1'b1, n);
    check(32'(n), 32'd30);
    repeat (3) @(negedge clk_sys);
    check(32'(srp_busy), 32'h0);
    $display("test session done");
    @(posedge clk_sys);
    plug_identity_pin <= 1'b0;
    low_speed_req <= 1'b0;
    repeat (6) @(posedge clk_sys);
    check(32'({host_role, dp_pullup_en}), 32'h2);
    for (i = 0; i < 300 && sof !== 1'b1; i++) @(negedge clk_sys);
    for (n = 0; n < 300 && (n == 0 || sof !== 1'b1); n++) @(negedge clk_sys);
    check(32'(n), 32'd200);
    @(posedge clk_sys);
    foreach (rows[r]) run_row(rows[r]);
    check(32'(ack_count), 32'd3);
    $display("test schedule done");
    low_speed_req <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check(32'(low_speed), 32'h1);
    count_ticks(6);
    $display("test low speed done");
    summarize();
  end
endmodule : usb_otg_role_speed_policy_tb_top

// [test/usb_peer_model.sv]
`timescale 1ns/1ps

module usb_peer_model (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic send, // bench command: send one token
  input wire logic [3:0] send_ep, // endpoint of that token
  input wire logic [1:0] send_type, // type of that token
  input wire logic tok_valid, // host started a transfer
  input wire logic tok_handshake, // host waits for our handshake
  output logic rx_tok_valid, // token towards the block
  output logic [3:0] rx_tok_ep, // token endpoint
  output logic [1:0] rx_tok_type, // token type
  output int ack_count // handshakes returned
);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_tok_valid <= 1'b0;
      rx_tok_ep <= 4'h0;
      rx_tok_type <= 2'h0;
      ack_count <= 0;
    end else begin
      rx_tok_valid <= send;
      // Idle fields toggle so a stale token never looks like a fresh one
      rx_tok_ep <= send ? send_ep : ~rx_tok_ep;
      rx_tok_type <= send ? send_type : ~rx_tok_type;
      // Iso data is taken without answer; everything else is acknowledged
      if (tok_valid && tok_handshake) ack_count <= ack_count + 1;
    end
  end
endmodule : usb_peer_model

// [test/usb_policy_props.sv]
`timescale 1ns/1ps
`include "usb_policy_defs.svh"

module usb_policy_props
  import usb_policy_pkg::*;
#(
  parameter int SRP_GAP_CYC = 5
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic plug_identity_pin, // plug identity pin
  input wire logic hnp_request, // role swap pulse
  input wire logic session_req, // session request pulse
  input wire logic req_valid, // host request
  input wire logic [1:0] req_type, // request type
  input wire logic [3:0] req_ep, // request endpoint
  input wire logic [`DEV_ADDR_W-1:0] req_addr, // request address
  input wire logic req_ready, // request grantable
  input wire logic host_role, // host role
  input wire logic low_speed, // low speed active
  input wire logic dp_pullup_en, // D+ pull-up
  input wire logic dm_pullup_en, // D- pull-up
  input wire logic tok_valid, // transfer start
  input xfer_t tok_type, // started type
  input wire logic [3:0] tok_ep, // started endpoint
  input wire logic [`DEV_ADDR_W-1:0] tok_addr, // started address
  input wire logic tok_handshake, // handshake expected
  input wire logic tok_crc_check, // CRC checked
  input wire logic rx_tok_accept, // token accepted
  input wire logic srp_dline_pulse, // data-line pulse
  input wire logic srp_vbus_pulse, // supply pulse
  input wire logic srp_busy // session request running
);
  // Gap plus two cycles of slack for the registered state change
  localparam int GAP_MAX = SRP_GAP_CYC + 2;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_grant;
    req_valid && req_ready;
  endsequence
  sequence s_plug_settled;
    $changed(plug_identity_pin) ##1 (!hnp_request && $stable(plug_identity_pin))[*3];
  endsequence
  sequence s_srp_start;
    session_req && !srp_busy && !host_role && plug_identity_pin;
  endsequence

  a_grant_token: assert property (s_grant |=> tok_valid && tok_ep == $past(req_ep)
    && tok_addr == $past(req_addr)) else $error("token does not follow grant");
  a_token_host: assert property (tok_valid |-> $past(host_role))
    else $error("token started outside host role");
  a_iso_no_hs: assert property (tok_valid && tok_type == XFER_ISO |->
    !tok_handshake && tok_crc_check) else $error("iso transfer expects handshake");
  a_other_hs: assert property (tok_valid && tok_type != XFER_ISO |->
    tok_handshake && tok_crc_check) else $error("non-iso transfer lacks handshake");
  a_ep0_ctrl: assert property (req_valid && req_ready && req_ep == 4'h0 |->
    req_type == 2'h0) else $error("endpoint zero granted non-control");
  a_role_plug: assert property (s_plug_settled |=> host_role == !plug_identity_pin)
    else $error("role does not follow plug");
  a_host_no_pull: assert property (host_role && $past(host_role) |-> !dp_pullup_en)
    else $error("pull-up on in host role");
  a_dm_off: assert property (!dm_pullup_en)
    else $error("D- pull-up enabled");
  a_ls_host: assert property (low_speed |-> host_role || $past(host_role))
    else $error("low speed outside host role");
  a_rx_periph: assert property (rx_tok_accept |-> !$past(host_role))
    else $error("token accepted in host role");
  a_srp_begin: assert property (s_srp_start |=> srp_busy && srp_dline_pulse)
    else $error("session request not started");
  a_srp_vbus: assert property ($fell(srp_dline_pulse) && srp_busy |->
    !srp_vbus_pulse ##[1:GAP_MAX] srp_vbus_pulse) else $error("supply pulse missing");
endmodule : usb_policy_props

bind usb_otg_role_speed_policy usb_policy_props #(.SRP_GAP_CYC(SRP_GAP_CYC)) usb_policy_props_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .plug_identity_pin(plug_identity_pin),
  .hnp_request(hnp_request), .session_req(session_req), .req_valid(req_valid),
  .req_type(req_type), .req_ep(req_ep), .req_addr(req_addr), .req_ready(req_ready),
  .host_role(host_role), .low_speed(low_speed), .dp_pullup_en(dp_pullup_en),
  .dm_pullup_en(dm_pullup_en), .tok_valid(tok_valid), .tok_type(tok_type),
  .tok_ep(tok_ep), .tok_addr(tok_addr), .tok_handshake(tok_handshake),
  .tok_crc_check(tok_crc_check), .rx_tok_accept(rx_tok_accept),
  .srp_dline_pulse(srp_dline_pulse), .srp_vbus_pulse(srp_vbus_pulse), .srp_busy(srp_busy));
